// ===== mxb_consts.vh
/*
  Shared constants for the exchange/XOR core and its bus pin sequencer:
  machine-cycle phases, opcode encodings, address constants, field ranges.
  Assumes it is included by bare name from every design file that needs it.
*/
`ifndef MXB_CONSTS_VH
`define MXB_CONSTS_VH

// Program counter and paging
`define MXB_PC_W        12
`define MXB_PAGE_W      8
`define MXB_PC_ONE      12'h001
`define MXB_RESET_PC    12'h000
`define MXB_INT_VECTOR  12'h003

// Working register bank bases for the alternate bank and the default bank
`define MXB_BANK1_BASE  5'h18
`define MXB_BANK0_BASE  5'h00

// Nibble ranges of a byte
`define MXB_LO_NIB      3:0
`define MXB_HI_NIB      7:4

// Expander nibble commands
`define MXB_EXP_READ    2'h0
`define MXB_EXP_WRITE   2'h1

// Machine-cycle phases, one clock each
`define MXB_PH_ALE      3'h0
`define MXB_PH_ADDR     3'h1
`define MXB_PH_STRB     3'h2
`define MXB_PH_SAMP     3'h3
`define MXB_PH_LAST     3'h4
`define MXB_PH_STEP     3'h1

// Opcodes, partial fields compared against the upper opcode bits
`define MXB_OP_XCH_R    5'h05
`define MXB_OP_XCH_I    7'h10
`define MXB_OP_EXCHANGE_LOW_NIBBLE_OP     7'h18
`define MXB_OP_XRL_R    5'h1B
`define MXB_OP_XRL_I    7'h68
`define MXB_OP_MOV_RA   5'h15
`define MXB_OP_MOVX_RD  7'h40
`define MXB_OP_MOVX_WR  7'h48
`define MXB_OP_MOVD_RD  6'h03
`define MXB_OP_MOVD_WR  6'h0F

// Opcodes, full byte
`define MXB_OP_XRL_IMM  8'hD3
`define MXB_OP_MOV_IMM  8'h23
`define MXB_OP_EN_I     8'h05
`define MXB_OP_DIS_I    8'h15
`define MXB_OP_SEL_RB0  8'hC5
`define MXB_OP_SEL_RB1  8'hD5
`define MXB_OP_ENT0     8'h75
`define MXB_OP_STRT_CNT 8'h45
`define MXB_OP_STOP_CNT 8'h65
`define MXB_OP_JT0      8'h36
`define MXB_OP_JUMP_IF_TEST0_LOW     8'h26
`define MXB_OP_JT1      8'h56
`define MXB_OP_JUMP_IF_TEST1_LOW     8'h46
`define MXB_OP_JNI      8'h86
`define MXB_OP_OUTL     8'h02
`define MXB_OP_INS      8'h08
`define MXB_OP_RETR     8'h93

`endif

// ===== mxb_event_counter.v
/*
  Event counter that advances on each high-to-low transition of its input
  while enabled.
  Assumes the event input is synchronous to i_clk.
*/
`timescale 1ns/10ps
`include "mxb_consts.vh"

module mxb_event_counter #(
  parameter CNT_W = 8
)(
  input  wire             i_clk,
  input  wire             i_rstn,
  input  wire             i_enable,
  input  wire             i_event,
  output wire [CNT_W-1:0] o_count
);

  reg             prev_reg;
  reg [CNT_W-1:0] count_reg;

  assign o_count = count_reg;

  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      prev_reg  <= 1'b0;
      count_reg <= {CNT_W{1'b0}};
    end
    else
    begin
      prev_reg <= i_event;
      if (i_enable && prev_reg && !i_event)
        count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// ===== mxb_core.v
/*
  Core sequencer: exchange and XOR operations on the accumulator, a small
  control subset, and the external pin protocol (multiplexed data port,
  high address nibble, address latch, read, write, fetch and expander strobes).
  Assumes all pin inputs are synchronous to i_clk and that the internal
  program store answers combinationally on i_expander_strobe_rom_data.
*/
`timescale 1ns/10ps
`include "mxb_consts.vh"

module mxb_core #(
  parameter                  RAM_AW    = 6,
  parameter [`MXB_PC_W:0]    ROM_DEPTH = 13'h0400,
  parameter                  CNT_W     = 8
)(
  input  wire                  i_clk,
  input  wire                  i_rstn,
  input  wire [7:0]            i_data_port_lines,
  output reg  [7:0]            o_data_port_lines,
  output reg                   o_data_port_lines_oe,
  input  wire [3:0]            i_high_nibble_lines,
  output reg  [3:0]            o_high_nibble_lines,
  output reg                   o_high_nibble_lines_oe,
  output reg                   o_address_latch,
  output reg                   o_program_fetch_strobe_n,
  output reg                   o_read_strobe_n,
  output reg                   o_write_strobe_n,
  output reg                   o_expander_strobe,
  input  wire                  i_test_input_zero,
  output reg                   o_test_input_zero,
  output reg                   o_test_input_zero_oe,
  input  wire                  i_test_input_one,
  input  wire                  i_interrupt_n,
  input  wire                  i_single_step_n,
  input  wire                  i_external_fetch_force,
  output wire [`MXB_PC_W-1:0]  o_expander_strobe_rom_addr,
  input  wire [7:0]            i_expander_strobe_rom_data,
  output wire [7:0]            o_accumulator,
  output wire [CNT_W-1:0]      o_event_count
);

  localparam ST_FETCH = 3'b001;
  localparam ST_EXEC2 = 3'b010;
  localparam ST_HALT  = 3'b100;

  reg  [2:0]            state_reg;
  reg  [2:0]            state_next;
  reg  [2:0]            phase_reg;
  reg  [`MXB_PC_W-1:0]  pc_reg;
  reg  [`MXB_PC_W-1:0]  pc_next;
  reg  [`MXB_PC_W-1:0]  pc_seq;
  reg  [`MXB_PC_W-1:0]  ret_pc_reg;
  reg  [7:0]            acc_reg;
  reg  [7:0]            acc_next;
  reg  [7:0]            op_reg;
  reg                   bank_reg;
  reg                   ret_bank_reg;
  reg                   int_en_reg;
  reg                   in_service_reg;
  reg  [7:0]            bus_latch_reg;
  reg                   bus_static_reg;
  reg                   clk_out_en_reg;
  reg                   cnt_en_reg;
  reg                   ram_we;
  reg  [RAM_AW-1:0]     ram_waddr;
  reg  [7:0]            ram_wdata;
  reg  [7:0]            bus_d;
  reg                   bus_oe;
  reg  [3:0]            nib_d;
  reg                   nib_oe;
  reg  [7:0]            ram [0:(1<<RAM_AW)-1];

  wire st_fetch  = state_reg[0];
  wire st_exec2  = state_reg[1];
  wire st_halt   = state_reg[2];
  wire ph_last   = (phase_reg == `MXB_PH_LAST);
  wire addr_ph   = (phase_reg == `MXB_PH_ALE) || (phase_reg == `MXB_PH_ADDR);
  wire strobe_ph = (phase_reg == `MXB_PH_STRB) || (phase_reg == `MXB_PH_SAMP);

  // External access is not latched per cycle; it must be held static while running
  wire fetch_ext = i_external_fetch_force || ({1'b0, pc_reg} >= ROM_DEPTH);
  wire [7:0] fetch_byte = fetch_ext ? i_data_port_lines : i_expander_strobe_rom_data;
  wire [7:0] cur_op     = st_fetch ? fetch_byte : op_reg;

  wire is_xch_r   = (cur_op[7:3] == `MXB_OP_XCH_R);
  wire is_xch_i   = (cur_op[7:1] == `MXB_OP_XCH_I);
  wire is_exchange_low_nibble_op    = (cur_op[7:1] == `MXB_OP_EXCHANGE_LOW_NIBBLE_OP);
  wire is_xrl_r   = (cur_op[7:3] == `MXB_OP_XRL_R);
  wire is_xrl_i   = (cur_op[7:1] == `MXB_OP_XRL_I);
  wire is_mov_ra  = (cur_op[7:3] == `MXB_OP_MOV_RA);
  wire is_movx_rd = (cur_op[7:1] == `MXB_OP_MOVX_RD);
  wire is_movx_wr = (cur_op[7:1] == `MXB_OP_MOVX_WR);
  wire is_movd_rd = (cur_op[7:2] == `MXB_OP_MOVD_RD);
  wire is_movd_wr = (cur_op[7:2] == `MXB_OP_MOVD_WR);
  wire is_outl    = (cur_op == `MXB_OP_OUTL);
  wire is_ins     = (cur_op == `MXB_OP_INS);
  wire is_jump    = (cur_op == `MXB_OP_JT0) || (cur_op == `MXB_OP_JUMP_IF_TEST0_LOW) || (cur_op == `MXB_OP_JT1) ||
                    (cur_op == `MXB_OP_JUMP_IF_TEST1_LOW) || (cur_op == `MXB_OP_JNI);
  wire needs_imm  = (cur_op == `MXB_OP_XRL_IMM) || (cur_op == `MXB_OP_MOV_IMM) || is_jump;
  wire is_bus2    = is_movx_rd || is_movx_wr || is_outl || is_ins || is_movd_rd || is_movd_wr;
  wire two_cycle  = needs_imm || is_bus2;

  wire jump_taken = ((cur_op == `MXB_OP_JT0)  &&  i_test_input_zero) ||
                    ((cur_op == `MXB_OP_JUMP_IF_TEST0_LOW) && !i_test_input_zero) ||
                    ((cur_op == `MXB_OP_JT1)  &&  i_test_input_one)  ||
                    ((cur_op == `MXB_OP_JUMP_IF_TEST1_LOW) && !i_test_input_one)  ||
                    ((cur_op == `MXB_OP_JNI)  && !i_interrupt_n);

  // Cycle kinds; each strobe belongs to exactly one kind, so they cannot overlap
  wire cyc_fetch_ext = (st_fetch || (st_exec2 && needs_imm)) && fetch_ext;
  wire cyc_rd        = st_exec2 && (is_movx_rd || is_ins);
  wire cyc_wr        = st_exec2 && (is_movx_wr || is_outl);
  wire cyc_movx      = st_exec2 && (is_movx_rd || is_movx_wr);
  wire cyc_exp       = st_exec2 && (is_movd_rd || is_movd_wr);

  wire exec1     = ph_last && st_fetch && !two_cycle;
  wire exec2     = ph_last && st_exec2;
  wire end_instr = exec1 || exec2;
  wire irq_take  = int_en_reg && !in_service_reg && !i_interrupt_n;

  wire [4:0] bank_base = bank_reg ? `MXB_BANK1_BASE : `MXB_BANK0_BASE;
  wire [RAM_AW-1:0] wreg_addr = {{(RAM_AW-5){1'b0}}, bank_base | {2'h0, cur_op[2:0]}};
  wire [RAM_AW-1:0] ptr_addr  = {{(RAM_AW-5){1'b0}}, bank_base | {4'h0, cur_op[0]}};
  wire [7:0]        wreg_val  = ram[wreg_addr];
  wire [7:0]        ptr_val   = ram[ptr_addr];
  wire [RAM_AW-1:0] ind_addr  = ptr_val[RAM_AW-1:0];
  wire [7:0]        ind_val   = ram[ind_addr];

  assign o_expander_strobe_rom_addr = pc_reg;
  assign o_accumulator   = acc_reg;

  // Sequencing: next program counter and state
  always @*
  begin
    state_next = state_reg;
    pc_seq     = pc_reg;
    if (st_halt)
    begin
      if (i_single_step_n)
        state_next = ST_FETCH;
    end
    else if (ph_last)
    begin
      case (state_reg)
        ST_FETCH:
        begin
          pc_seq = pc_reg + `MXB_PC_ONE;
          if (two_cycle)
            state_next = ST_EXEC2;
          else if (cur_op == `MXB_OP_RETR)
            pc_seq = ret_pc_reg;
        end
        ST_EXEC2:
        begin
          state_next = ST_FETCH;
          if (needs_imm)
            pc_seq = pc_reg + `MXB_PC_ONE;
          if (is_jump && jump_taken)
            pc_seq = {pc_reg[`MXB_PC_W-1:`MXB_PAGE_W], fetch_byte};
        end
        default:
          state_next = ST_FETCH;
      endcase
      if (end_instr && !irq_take && !i_single_step_n)
        state_next = ST_HALT;
    end
    pc_next = (end_instr && irq_take) ? `MXB_INT_VECTOR : pc_seq;
  end

  // Data path: accumulator and internal memory write
  always @*
  begin
    acc_next  = acc_reg;
    ram_we    = 1'b0;
    ram_waddr = wreg_addr;
    ram_wdata = acc_reg;
    if (exec1)
    begin
      if (is_xch_r)
      begin
        acc_next = wreg_val;
        ram_we   = 1'b1;
      end
      else if (is_xch_i)
      begin
        acc_next  = ind_val;
        ram_we    = 1'b1;
        ram_waddr = ind_addr;
      end
      else if (is_exchange_low_nibble_op)
      begin
        acc_next  = {acc_reg[`MXB_HI_NIB], ind_val[`MXB_LO_NIB]};
        ram_we    = 1'b1;
        ram_waddr = ind_addr;
        ram_wdata = {ind_val[`MXB_HI_NIB], acc_reg[`MXB_LO_NIB]};
      end
      else if (is_xrl_r)
        acc_next = acc_reg ^ wreg_val;
      else if (is_xrl_i)
        acc_next = acc_reg ^ ind_val;
      else if (is_mov_ra)
        ram_we = 1'b1;
    end
    else if (exec2)
    begin
      if (cur_op == `MXB_OP_XRL_IMM)
        acc_next = acc_reg ^ fetch_byte;
      else if (cur_op == `MXB_OP_MOV_IMM)
        acc_next = fetch_byte;
      else if (is_movx_rd || is_ins)
        acc_next = i_data_port_lines;
      else if (is_movd_rd)
        acc_next = {4'h0, i_high_nibble_lines};
    end
  end

  always @(posedge i_clk)
  begin
    if (ram_we)
      ram[ram_waddr] <= ram_wdata;
  end

  // Pin drive before the output flops; outputs lag this by one clock
  always @*
  begin
    bus_d  = bus_latch_reg;
    bus_oe = bus_static_reg;
    nib_d  = pc_reg[`MXB_PC_W-1:`MXB_PAGE_W];
    nib_oe = 1'b0;
    if (cyc_fetch_ext)
    begin
      bus_d  = pc_reg[`MXB_PAGE_W-1:0];
      bus_oe = addr_ph;
      nib_oe = 1'b1;
    end
    else if (cyc_movx)
    begin
      bus_d  = addr_ph ? ptr_val : acc_reg;
      bus_oe = addr_ph || cyc_wr;
    end
    else if (cyc_wr)
    begin
      bus_d  = acc_reg;
      bus_oe = 1'b1;
    end
    else if (cyc_rd)
      bus_oe = 1'b0;
    if (cyc_exp)
    begin
      nib_oe = addr_ph || is_movd_wr;
      nib_d  = addr_ph ? {(is_movd_wr ? `MXB_EXP_WRITE : `MXB_EXP_READ), op_reg[1:0]} : acc_reg[`MXB_LO_NIB];
    end
  end

  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_reg                <= ST_FETCH;
      phase_reg                <= `MXB_PH_ALE;
      pc_reg                   <= `MXB_RESET_PC;
      ret_pc_reg               <= `MXB_RESET_PC;
      acc_reg                  <= 8'h00;
      op_reg                   <= 8'h00;
      bank_reg                 <= 1'b0;
      ret_bank_reg             <= 1'b0;
      int_en_reg               <= 1'b0;
      in_service_reg           <= 1'b0;
      bus_latch_reg            <= 8'h00;
      bus_static_reg           <= 1'b0;
      clk_out_en_reg           <= 1'b0;
      cnt_en_reg               <= 1'b0;
      o_data_port_lines        <= 8'h00;
      o_data_port_lines_oe     <= 1'b0;
      o_high_nibble_lines      <= 4'h0;
      o_high_nibble_lines_oe   <= 1'b0;
      o_address_latch          <= 1'b0;
      o_program_fetch_strobe_n <= 1'b1;
      o_read_strobe_n          <= 1'b1;
      o_write_strobe_n         <= 1'b1;
      o_expander_strobe        <= 1'b1;
      o_test_input_zero        <= 1'b0;
      o_test_input_zero_oe     <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      pc_reg    <= pc_next;
      acc_reg   <= acc_next;
      if (!st_halt)
        phase_reg <= ph_last ? `MXB_PH_ALE : phase_reg + `MXB_PH_STEP;
      if (ph_last && st_fetch)
        op_reg <= fetch_byte;
      if (exec1)
      begin
        case (cur_op)
          `MXB_OP_EN_I:     int_en_reg <= 1'b1;
          `MXB_OP_DIS_I:    int_en_reg <= 1'b0;
          `MXB_OP_SEL_RB0:  bank_reg <= 1'b0;
          `MXB_OP_SEL_RB1:  bank_reg <= 1'b1;
          `MXB_OP_ENT0:     clk_out_en_reg <= 1'b1;
          `MXB_OP_STRT_CNT: cnt_en_reg <= 1'b1;
          `MXB_OP_STOP_CNT: cnt_en_reg <= 1'b0;
          `MXB_OP_RETR:
          begin
            in_service_reg <= 1'b0;
            bank_reg       <= ret_bank_reg;
          end
          default:          bank_reg <= bank_reg;
        endcase
      end
      if (exec2 && is_outl)
      begin
        bus_latch_reg  <= acc_reg;
        bus_static_reg <= 1'b1;
      end
      else if ((exec2 && is_movx_rd) || (exec2 && is_movx_wr) || (ph_last && cyc_fetch_ext))
        bus_static_reg <= 1'b0;
      if (end_instr && irq_take)
      begin
        in_service_reg <= 1'b1;
        ret_pc_reg     <= pc_seq;
        ret_bank_reg   <= bank_reg;
      end
      o_data_port_lines        <= bus_d;
      o_data_port_lines_oe     <= bus_oe;
      o_high_nibble_lines      <= nib_d;
      o_high_nibble_lines_oe   <= nib_oe;
      o_address_latch          <= st_halt || (phase_reg == `MXB_PH_ALE);
      o_program_fetch_strobe_n <= !(cyc_fetch_ext && strobe_ph);
      o_read_strobe_n          <= !(cyc_rd && strobe_ph);
      o_write_strobe_n         <= !(cyc_wr && strobe_ph);
      // Write data stays driven for one clock after the strobe release edge: a one-clock hold
      o_expander_strobe        <= !(cyc_exp && strobe_ph);
      o_test_input_zero        <= st_halt || (phase_reg == `MXB_PH_ALE);
      o_test_input_zero_oe     <= clk_out_en_reg;
    end
  end

  mxb_event_counter #(
    .CNT_W (CNT_W)
  ) u_event_counter (
    .i_clk    (i_clk),
    .i_rstn   (i_rstn),
    .i_enable (cnt_en_reg),
    .i_event  (i_test_input_one),
    .o_count  (o_event_count)
  );

endmodule

// ===== mxb_core_assertions.sv
/*
  Pin protocol checker for mxb_core: strobe shapes, address phase, overlap.
  Assumes one clock domain and a bind to every mxb_core instance.
*/
`timescale 1ns/10ps
module mxb_core_assertions #(
  parameter [12:0] ROM_DEPTH = 13'h0400
)(
  input wire        i_clk,
  input wire        i_rstn,
  input wire        i_external_fetch_force,
  input wire        o_data_port_lines_oe,
  input wire [3:0]  o_high_nibble_lines,
  input wire        o_high_nibble_lines_oe,
  input wire        o_address_latch,
  input wire        o_program_fetch_strobe_n,
  input wire        o_read_strobe_n,
  input wire        o_write_strobe_n,
  input wire        o_expander_strobe,
  input wire        o_test_input_zero,
  input wire        o_test_input_zero_oe,
  input wire [11:0] o_expander_strobe_rom_addr
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  property p_ale_cycle;
    $fell(o_address_latch) |-> !o_address_latch [*4] ##1 o_address_latch;
  endproperty
  a_ale_cycle: assert property (p_ale_cycle) else $error("latch period wrong");

  // Margin of two covers the PC step taken during a fetch
  property p_fetch_int;
    !i_external_fetch_force && o_expander_strobe_rom_addr < ROM_DEPTH - 13'h002 |-> o_program_fetch_strobe_n;
  endproperty
  a_fetch_int: assert property (p_fetch_int) else $error("fetch strobe on internal fetch");

  property p_fetch;
    $fell(o_program_fetch_strobe_n) |-> !o_data_port_lines_oe && $past(o_data_port_lines_oe)
      && $past(o_address_latch, 2) && o_high_nibble_lines_oe && o_high_nibble_lines == o_expander_strobe_rom_addr[11:8]
      ##1 !o_program_fetch_strobe_n ##1 o_program_fetch_strobe_n;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch cycle shape wrong");

  property p_read;
    $fell(o_read_strobe_n) |-> !o_data_port_lines_oe && $past(o_address_latch, 2)
      ##1 !o_read_strobe_n ##1 o_read_strobe_n;
  endproperty
  a_read: assert property (p_read) else $error("read cycle shape wrong");

  property p_write;
    $fell(o_write_strobe_n) |-> o_data_port_lines_oe && $past(o_address_latch, 2)
      ##1 !o_write_strobe_n && o_data_port_lines_oe ##1 o_write_strobe_n;
  endproperty
  a_write: assert property (p_write) else $error("write cycle shape wrong");

  property p_excl;
    (o_read_strobe_n || o_write_strobe_n) && (o_program_fetch_strobe_n || (o_read_strobe_n && o_write_strobe_n));
  endproperty
  a_excl: assert property (p_excl) else $error("strobes overlap");

  property p_expander;
    $fell(o_expander_strobe) |-> $past(o_high_nibble_lines_oe) && $past(o_high_nibble_lines) < 4'h8
      ##1 !o_expander_strobe ##1 o_expander_strobe;
  endproperty
  a_expander: assert property (p_expander) else $error("expander cycle wrong");

  property p_tzero;
    o_test_input_zero_oe |-> o_test_input_zero == o_address_latch;
  endproperty
  a_tzero: assert property (p_tzero) else $error("test zero clock wrong");

  c_fetch: cover property ($fell(o_program_fetch_strobe_n));
  c_read: cover property ($fell(o_read_strobe_n));
  c_write: cover property ($fell(o_write_strobe_n));
  c_exp: cover property ($fell(o_expander_strobe));
endmodule

bind mxb_core mxb_core_assertions #(.ROM_DEPTH(ROM_DEPTH)) i_mxb_core_assertions (
  .i_clk, .i_rstn, .i_external_fetch_force, .o_data_port_lines_oe, .o_high_nibble_lines,
  .o_high_nibble_lines_oe, .o_address_latch, .o_program_fetch_strobe_n, .o_read_strobe_n,
  .o_write_strobe_n, .o_expander_strobe, .o_test_input_zero, .o_test_input_zero_oe, .o_expander_strobe_rom_addr
);

// ===== mxb_mem_model.sv
/*
  Program store and external memory model with a write log.
  Assumes the core's registered strobes; undriven lines flip every cycle.
*/
`timescale 1ns/10ps
module mxb_mem_model (
  input  wire        i_clk,
  input  wire [11:0] i_rom_addr,
  output wire [7:0]  o_rom_data,
  input  wire [7:0]  i_bus_out,
  input  wire        i_bus_oe,
  output wire [7:0]  o_bus,
  input  wire [3:0]  i_nib_out,
  input  wire        i_nib_oe,
  output wire [3:0]  o_nib,
  input  wire        i_ale,
  input  wire        i_fetch_n,
  input  wire        i_rd_n,
  input  wire        i_wr_n
);
  reg [7:0] expander_strobe [0:255];
  reg [7:0] dmem [0:255];
  reg [7:0] wr_addr [0:15];
  reg [7:0] wr_data [0:15];
  integer   wr_time [0:15];
  integer   log_n = 0;
  integer   fetch_cnt = 0;
  integer   clk_cnt = 0;
  reg [7:0] lat_lo = 8'h00;
  reg [7:0] bus_last = 8'h00;
  reg [3:0] nib_last = 4'h0;
  reg       ale_q = 1'b0;
  reg       wr_q = 1'b1;
  reg       fetch_q = 1'b1;
  wire       mem_en = !i_fetch_n || !i_rd_n;
  wire [7:0] mem_val = !i_fetch_n ? expander_strobe[lat_lo] : dmem[lat_lo];

  assign o_bus = i_bus_oe ? i_bus_out : (mem_en ? mem_val : ~bus_last);
  assign o_nib = i_nib_oe ? i_nib_out : ~nib_last;
  assign o_rom_data = expander_strobe[i_rom_addr[7:0]];

  always @(posedge i_clk)
  begin
    clk_cnt <= clk_cnt + 1;
    ale_q <= i_ale;
    wr_q <= i_wr_n;
    fetch_q <= i_fetch_n;
    bus_last <= o_bus;
    nib_last <= o_nib;
    if (ale_q && !i_ale)
      lat_lo <= o_bus;
    if (fetch_q && !i_fetch_n)
      fetch_cnt <= fetch_cnt + 1;
    if (wr_q && !i_wr_n)
    begin
      dmem[lat_lo] <= o_bus;
      wr_addr[log_n] <= lat_lo;
      wr_data[log_n] <= o_bus;
      wr_time[log_n] <= clk_cnt;
      log_n <= log_n + 1;
    end
  end
endmodule

// ===== mxb_core_tb.sv
/*
  Self-checking bench for mxb_core running small programs.
  Assumes mxb_mem_model on the bus; the write log is the observation point.
*/
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module mxb_core_tb;
  // Exchange and XOR walk; each 91 logs the accumulator
  localparam [343:0] EXPANDER_STROBE_A = {8'h23, 8'h40, 8'hA9, 8'h00, 8'h45, 8'h23, 8'h5A, 8'hAB, 8'h23, 8'hC3, 8'h2B,
    8'h91, 8'hD5, 8'h23, 8'h66, 8'hAB, 8'hC5, 8'h23, 8'h1B, 8'hA8, 8'h20, 8'h91, 8'hDB, 8'h91, 8'h28, 8'h91,
    8'h28, 8'h23, 8'hF7, 8'h30, 8'h91, 8'h20, 8'h91, 8'hD0, 8'h91, 8'hD3, 8'h3C, 8'h91, 8'h80, 8'h91, 8'h3D,
    8'h36, 8'h29};
  localparam [71:0] EXP_A = {8'h5A, 8'h66, 8'hA5, 8'h1B, 8'hFB, 8'h17, 8'hEC, 8'hD0, 8'h3E};
  localparam [143:0] EXPANDER_STROBE_C = {8'h23, 8'h40, 8'hA9, 8'h23, 8'h22, 8'h91, 8'h86, 8'h0A, 8'h23, 8'hEE, 8'h05,
    8'h23, 8'h77, 8'h91, 8'h75, 8'h02, 8'h86, 8'h10};
  reg         i_clk = 1'b0;
  reg         i_rstn = 1'b0;
  reg         t0_drv = 1'b1;
  reg         i_test_input_one = 1'b1;
  reg         i_interrupt_n = 1'b1;
  reg         i_single_step_n = 1'b1;
  reg         i_external_fetch_force = 1'b0;
  wire [7:0]  bus_out, bus, rom_data, acc, cnt;
  wire [3:0]  nib_out, nib;
  wire [11:0] rom_addr;
  wire        bus_oe, nib_oe, ale, fetch_n, rd_n, wr_n, exp_s, t0_out, t0_oe;
  wire        t0_pin = t0_oe ? t0_out : t0_drv;
  integer     fails = 0;
  integer     comparisons = 0;
  integer     k;

  reg  [3:0]  nib_q = 4'h0;
  reg  [3:0]  exp_cmd = 4'h0;
  reg  [3:0]  exp_dat = 4'h0;
  reg         exp_q = 1'b1;

  always #10 i_clk = ~i_clk;

  // Expander transfer capture: command nibble one clock before the strobe falls, data while it is low
  always @(posedge i_clk)
  begin
    nib_q <= nib_out;
    exp_q <= exp_s;
    if (exp_q && !exp_s)
    begin
      exp_cmd <= nib_q;
      exp_dat <= nib_out;
    end
  end

  mxb_core i_mxb_core (.i_clk(i_clk), .i_rstn(i_rstn), .i_data_port_lines(bus), .o_data_port_lines(bus_out),
    .o_data_port_lines_oe(bus_oe), .i_high_nibble_lines(nib), .o_high_nibble_lines(nib_out),
    .o_high_nibble_lines_oe(nib_oe), .o_address_latch(ale), .o_program_fetch_strobe_n(fetch_n),
    .o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n), .o_expander_strobe(exp_s), .i_test_input_zero(t0_pin),
    .o_test_input_zero(t0_out), .o_test_input_zero_oe(t0_oe), .i_test_input_one(i_test_input_one),
    .i_interrupt_n(i_interrupt_n), .i_single_step_n(i_single_step_n),
    .i_external_fetch_force(i_external_fetch_force), .o_expander_strobe_rom_addr(rom_addr), .i_expander_strobe_rom_data(rom_data),
    .o_accumulator(acc), .o_event_count(cnt));

  mxb_mem_model i_mxb_mem_model (.i_clk(i_clk), .i_rom_addr(rom_addr), .o_rom_data(rom_data),
    .i_bus_out(bus_out), .i_bus_oe(bus_oe), .o_bus(bus), .i_nib_out(nib_out), .i_nib_oe(nib_oe), .o_nib(nib),
    .i_ale(ale), .i_fetch_n(fetch_n), .i_rd_n(rd_n), .i_wr_n(wr_n));

  task print_verdict;
  begin
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  // Inputs always move 1 ns after the rising edge
  task tick(input integer n);
  begin
    repeat (n) @(posedge i_clk);
    #1;
  end
  endtask

  task load(input [343:0] img, input integer n);
  begin
    for (k = 0; k < n; k++)
      i_mxb_mem_model.expander_strobe[k] = img[8*n-1-8*k -: 8];
  end
  endtask

  // A fresh reset per program also exercises a reset in mid-run
  task restart(input ea);
  begin
    i_rstn = 1'b0;
    i_external_fetch_force = ea;
    tick(10);
    i_mxb_mem_model.log_n = 0;
    i_mxb_mem_model.fetch_cnt = 0;
    `CHK({ale, fetch_n, rd_n, wr_n, exp_s, acc}, 13'h0F00)
    i_rstn = 1'b1;
  end
  endtask

  task wait_log(input integer n);
  begin
    k = 0;
    while (i_mxb_mem_model.log_n < n && k < 3000)
    begin
      tick(1);
      k++;
    end
    if (k == 3000)
    begin
      fails++;
      $display("[ERR] %0t write log timeout", $time);
      print_verdict;
    end
  end
  endtask

  task test_exchange_xor(input ea);
  begin
    load(EXPANDER_STROBE_A, 43);
    i_mxb_mem_model.dmem[8'h1B] = 8'h3E;
    restart(ea);
    tick(100);
    repeat (5)
    begin
      i_test_input_one = 1'b0;
      tick(2);
      i_test_input_one = 1'b1;
      tick(2);
    end
    wait_log(9);
    tick(40);
    `CHK(i_mxb_mem_model.log_n, 9)
    for (k = 0; k < 9; k++)
    begin
      `CHK(i_mxb_mem_model.wr_data[k], EXP_A[71-8*k -: 8])
      `CHK(i_mxb_mem_model.wr_addr[k], 8'h40)
    end
    `CHK(i_mxb_mem_model.wr_time[2] - i_mxb_mem_model.wr_time[1], 15)
    `CHK(i_mxb_mem_model.wr_time[7] - i_mxb_mem_model.wr_time[6], 20)
    `CHK(cnt, 8'h05)
    `CHK(acc, 8'h3E)
    `CHK({exp_cmd, exp_dat}, 8'h5E)
    `CHK(i_mxb_mem_model.fetch_cnt > 0, ea)
    $display("test exchange_xor ea=%0d done", ea);
  end
  endtask

  task test_interrupt;
  begin
    load(EXPANDER_STROBE_C, 18);
    i_interrupt_n = 1'b0;
    restart(1'b0);
    wait_log(3);
    tick(60);
    `CHK(i_mxb_mem_model.log_n, 4)
    `CHK(i_mxb_mem_model.wr_data[3], 8'h77)
    `CHK({i_mxb_mem_model.wr_data[0], i_mxb_mem_model.wr_data[1]}, 16'h2222)
    `CHK(i_mxb_mem_model.wr_data[2], 8'h77)
    `CHK({bus_oe, bus_out}, 9'h177)
    `CHK(t0_oe, 1'b1)
    i_single_step_n = 1'b0;
    tick(40);
    `CHK({ale, fetch_n, rd_n, wr_n}, 4'hF)
    i_single_step_n = 1'b1;
    i_interrupt_n = 1'b1;
    tick(10);
    $display("test interrupt done");
  end
  endtask

  initial
  begin
    test_exchange_xor(1'b0);
    test_exchange_xor(1'b1);
    test_interrupt;
    print_verdict;
  end
endmodule
